// ==== logic/rcs_defs.vh ====
// Constants for the redundant CPU state controller.
// Included by every design file of the block; definitions only.
`ifndef RCS_DEFS_VH
`define RCS_DEFS_VH

// Encoded operating state (state_code output)
`define RCS_ST_STOP 4'h0
`define RCS_ST_STARTUP 4'h1
`define RCS_ST_RUN 4'h2
`define RCS_ST_ALIGN 4'h3
`define RCS_ST_UPDATE 4'h4
`define RCS_ST_HALT 4'h5
`define RCS_ST_ISOLATE 4'h6
`define RCS_ST_FAILED 4'h7
`define RCS_STATE_W 4

// Startup type select
`define RCS_START_WARM 1'b0
`define RCS_START_COLD 1'b1

// Single-bit error window: 6 months in days, at 100 MHz
`define RCS_SBE_WINDOW_DAYS 182
`define RCS_CLK_HZ 100000000
`define RCS_SBE_WINDOW_CYC (64'd182 * 64'd86400 * 64'd100000000)
`define RCS_SBE_LIMIT 2'h2

// Cycles after reaching run that still count as startup
`define RCS_EARLY_RUN_CYC 16'h0010

`endif

// ==== logic/rcs_sync.v ====
// Two-flop synchroniser for a bundle of level inputs.
// Assumes inputs come from pins outside the ref_clk domain.
`timescale 1ns/1ps
`include "rcs_defs.vh"

module rcs_sync #(
    parameter WIDTH = 8
)
(
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Data
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);

reg [WIDTH-1:0] meta;

// First stage feeds only the second stage
always @(posedge ref_clk)
begin
    if (rst)
    begin
        meta <= {WIDTH{1'b0}};
        dout <= {WIDTH{1'b0}};
    end
    else
    begin
        meta <= din;
        dout <= meta;
    end
end

endmodule

// ==== logic/rcs_sbe_window.v ====
// Counts single-bit errors inside a sliding-free fixed window.
// Assumes err_pulse is a one-cycle pulse on ref_clk.
`timescale 1ns/1ps
`include "rcs_defs.vh"

module rcs_sbe_window #(
    parameter [63:0] WINDOW_CYC = `RCS_SBE_WINDOW_CYC
)
(
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Events
    input wire enable,
    input wire err_pulse,
    output reg limit_hit
);

reg [63:0] age;
reg [1:0] count;

// Window opens on the first error and closes after WINDOW_CYC cycles
always @(posedge ref_clk)
begin
    if (rst || !enable)
    begin
        age <= 64'h0;
        count <= 2'h0;
        limit_hit <= 1'b0;
    end
    else
    begin
        limit_hit <= 1'b0;
        if (count != 2'h0 && age >= WINDOW_CYC - 64'h1)
        begin
            // Window expired; a new error restarts it
            age <= 64'h0;
            count <= err_pulse ? 2'h1 : 2'h0;
        end
        else
        begin
            if (count != 2'h0)
                age <= age + 64'h1;
            if (err_pulse)
            begin
                if (count == `RCS_SBE_LIMIT - 2'h1)
                    limit_hit <= 1'b1;
                if (count != 2'h3)
                    count <= count + 2'h1;
            end
        end
    end
end

endmodule

// ==== logic/rcs_ctrl.v ====
// Contract
// RULE1: Power-up leaves both CPUs stopped until startup request
// RULE2: Startup request enters startup, runs matching handler
// RULE3: Successful startup makes master run solo
// RULE4: Refuse alignment while monitor or watch active
// RULE5: Standby request aligns; master copies differing program
// RULE6: After alignment master copies all dynamic data
// RULE7: After update both run lockstep, except swap
// RULE8: Redundancy needs equal hardware and firmware versions
// RULE9: Stay stopped without a loaded configuration
// RULE10: Memory clear affects only this CPU
// RULE11: Master runs startup, sets switched and own I/O
// RULE12: Standby startup runs no handler, own I/O only
// RULE13: Master drops early in startup, standby takes over
// RULE14: Master stays run while reserve aligns or updates
// RULE15: Reject breakpoint halts while redundant
// RULE16: CPU or link loss ends redundancy; mismatch isolates
// RULE17: Halt only from startup or solo run; blocks alignment
// RULE18: Isolation only from redundant; other becomes master
// RULE19: One-sided trap, checksum, multibit error isolates; code does not isolate if sbe_limit fires in the same cycle
// RULE20: Mismatch isolates standby, option sends it stop
// RULE21: Two single-bit errors in six months call handler
// RULE22: Isolation self-test: failed, or realign and swap
// RULE23: Expose encoded state and master flag
//
// Operating-state controller of one CPU in a redundant pair.
// Assumes pin-level events are synchronised here; pulse inputs come from ref_clk logic.
`timescale 1ns/1ps
`include "rcs_defs.vh"

module rcs_ctrl #(
    parameter [63:0] SBE_WINDOW_CYC = `RCS_SBE_WINDOW_CYC
)
(
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Operator requests (one-cycle pulses, ref_clk domain; start_type is a level)
    input wire start_req,
    input wire stop_req,
    input wire halt_req,
    input wire resume_req,
    input wire breakpoint_req,
    input wire mem_clear_req,
    input wire start_type,
    // Configuration
    input wire config_loaded,
    input wire mismatch_to_stop,
    input wire monitor_open,
    input wire watch_active,
    input wire [7:0] hw_version,
    input wire [7:0] fw_version,
    // Partner link (pins, asynchronous levels)
    input wire link_ok,
    input wire partner_alive,
    input wire partner_is_master,
    input wire partner_run,
    input wire partner_align_req,
    input wire [7:0] partner_hw_version,
    input wire [7:0] partner_fw_version,
    // Work-step results (ref_clk domain; one-cycle pulses, except levels program_differs and selftest_fault)
    input wire startup_done,
    input wire program_differs,
    input wire align_done,
    input wire update_done,
    input wire selftest_done,
    input wire selftest_fault,
    // Error events (one-cycle pulses, ref_clk domain)
    input wire prog_error_trap,
    input wire checksum_error,
    input wire multibit_error,
    input wire single_bit_error,
    input wire memory_image_mismatch,
    // Status and actions
    output reg [3:0] state_code,
    output reg is_master,
    output reg restart_handler,
    output reg cold_restart_handler,
    output reg param_switched_io,
    output reg param_own_io,
    output reg program_copy,
    output reg data_copy,
    output reg align_request,
    output reg selftest_run,
    output reg cpu_hardware_fault_handler,
    output reg breakpoint_reject,
    output reg align_refused,
    output reg mem_clear,
    output reg diag_msg,
    output reg lockstep
);

// One-hot states
localparam S_STOP = 8'h01;
localparam S_STARTUP = 8'h02;
localparam S_RUN = 8'h04;
localparam S_ALIGN = 8'h08;
localparam S_UPDATE = 8'h10;
localparam S_HALT = 8'h20;
localparam S_ISOLATE = 8'h40;
localparam S_FAILED = 8'h80;

reg [7:0] state;
reg [7:0] next_state;
reg next_master;
reg redundant;
reg next_redundant;
reg swap_pending;
reg next_swap_pending;
reg [15:0] run_age;
reg was_halt;
wire sbe_limit;

// Synchronised link pins
wire [3:0] link_sync;
wire [31:0] ver_sync;
wire s_link_ok = link_sync[0];
wire s_partner_alive = link_sync[1];
wire s_partner_master = link_sync[2];
wire s_partner_run = link_sync[3];

rcs_sync #(.WIDTH(4)) u_sync_link (
    .ref_clk(ref_clk),
    .rst(rst),
    .din({partner_run, partner_is_master, partner_alive, link_ok}),
    .dout(link_sync)
);

// Versions and alignment request also cross from the partner
rcs_sync #(.WIDTH(32)) u_sync_ver (
    .ref_clk(ref_clk),
    .rst(rst),
    .din({partner_hw_version, partner_fw_version, hw_version, fw_version}),
    .dout(ver_sync)
);

wire [0:0] areq_sync;
rcs_sync #(.WIDTH(1)) u_sync_areq (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(partner_align_req),
    .dout(areq_sync)
);

// Versions must match exactly before redundancy
wire versions_match = (ver_sync[31:24] == ver_sync[15:8]) &&
    (ver_sync[23:16] == ver_sync[7:0]); // RULE8
wire link_lost = !s_link_ok || !s_partner_alive;
// Halted master keeps the reserve in stop; a master still in startup also holds it off
wire partner_held = s_partner_master && !s_partner_run; // RULE17
wire one_sided_err = prog_error_trap | checksum_error | multibit_error;
// Monitor or watch table blocks alignment
wire align_blocked = monitor_open | watch_active; // RULE4

// Single-bit error counter runs only while redundant
rcs_sbe_window #(.WINDOW_CYC(SBE_WINDOW_CYC)) u_sbe (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(redundant),
    .err_pulse(single_bit_error),
    .limit_hit(sbe_limit)
);

// Encoded state for the status output
function [3:0] enc_state;
    input [7:0] st;
    begin
        case (st)
            S_STARTUP: enc_state = `RCS_ST_STARTUP;
            S_RUN: enc_state = `RCS_ST_RUN;
            S_ALIGN: enc_state = `RCS_ST_ALIGN;
            S_UPDATE: enc_state = `RCS_ST_UPDATE;
            S_HALT: enc_state = `RCS_ST_HALT;
            S_ISOLATE: enc_state = `RCS_ST_ISOLATE;
            S_FAILED: enc_state = `RCS_ST_FAILED;
            default: enc_state = `RCS_ST_STOP;
        endcase
    end
endfunction

// Next-state logic; error events outrank operator requests
always @*
begin
    next_state = state;
    next_master = is_master;
    next_redundant = redundant;
    next_swap_pending = swap_pending;
    case (state)
        S_STOP:
        begin
            // Only a loaded configuration may leave stop
            if (start_req && config_loaded && !partner_held) // RULE1 RULE9 RULE17
            begin
                next_state = S_STARTUP; // RULE2
                next_master = !(s_partner_master && s_partner_run);
            end
        end
        S_STARTUP:
        begin
            if (stop_req)
                next_state = S_STOP;
            else if (halt_req)
                next_state = S_HALT; // RULE17
            else if (startup_done)
                next_state = is_master ? S_RUN : S_ALIGN; // RULE3
        end
        S_RUN:
        begin
            if (redundant && link_lost)
            begin
                // Partner or link gone: carry on solo as master
                next_redundant = 1'b0; // RULE16
                next_master = 1'b1;
            end
            else if (redundant && memory_image_mismatch && !is_master)
            begin
                next_redundant = 1'b0;
                next_state = mismatch_to_stop ? S_STOP : S_ISOLATE; // RULE20 RULE16
            end
            else if (redundant && memory_image_mismatch)
                next_redundant = 1'b0; // RULE20
            else if (redundant && one_sided_err && !sbe_limit)
            begin
                next_redundant = 1'b0;
                next_master = 1'b0;
                next_state = S_ISOLATE; // RULE19 RULE18
            end
            else if (redundant && !s_partner_run && !link_lost)
            begin
                // Partner went to isolation: become master, solo
                next_redundant = 1'b0; // RULE18
                next_master = 1'b1;
            end
            else if (stop_req)
            begin
                next_state = S_STOP;
                next_redundant = 1'b0;
            end
            else if (halt_req && !redundant)
                next_state = S_HALT; // RULE17
            else if (redundant && swap_pending)
            begin
                // Automatic role swap after recovery
                next_master = !is_master; // RULE22 RULE7
                next_swap_pending = 1'b0;
            end
            else if (!redundant && !is_master && s_partner_master && versions_match)
                next_state = S_ALIGN; // RULE5
            else if (!is_master && !s_partner_run && run_age < `RCS_EARLY_RUN_CYC)
                next_master = 1'b1; // RULE13
        end
        S_ALIGN:
        begin
            if (link_lost || stop_req)
                next_state = S_STOP;
            else if (align_done)
                next_state = S_UPDATE; // RULE6
        end
        S_UPDATE:
        begin
            if (link_lost || stop_req)
                next_state = S_STOP;
            else if (update_done && versions_match)
            begin
                next_state = S_RUN;
                next_redundant = 1'b1; // RULE7 RULE8
            end
        end
        S_HALT:
        begin
            if (stop_req)
                next_state = S_STOP;
            else if (resume_req)
                next_state = S_RUN;
        end
        S_ISOLATE:
        begin
            // Full self-test; pass realigns while the partner runs, else stops; fault is terminal
            if (selftest_done && selftest_fault)
                next_state = S_FAILED; // RULE22
            else if (selftest_done && !link_lost && s_partner_run)
            begin
                next_state = S_ALIGN;
                next_swap_pending = 1'b1; // RULE22
            end
            else if (selftest_done)
                next_state = S_STOP;
        end
        S_FAILED:
            next_state = S_FAILED;
        default:
            next_state = S_STOP;
    endcase
end

// State and role registers
always @(posedge ref_clk)
begin
    if (rst)
    begin
        state <= S_STOP; // RULE1
        is_master <= 1'b0;
        redundant <= 1'b0;
        swap_pending <= 1'b0;
        run_age <= 16'h0000;
        was_halt <= 1'b0;
    end
    else
    begin
        state <= next_state;
        is_master <= next_master;
        redundant <= next_redundant;
        swap_pending <= next_swap_pending;
        was_halt <= (state == S_HALT);
        // Early-run window detects a master dropping right after startup
        if (state != S_RUN)
            run_age <= 16'h0000;
        else if (run_age != 16'hFFFF)
            run_age <= run_age + 16'h0001;
    end
end

// Registered action and status outputs
always @(posedge ref_clk)
begin
    if (rst)
    begin
        state_code <= `RCS_ST_STOP;
        restart_handler <= 1'b0;
        cold_restart_handler <= 1'b0;
        param_switched_io <= 1'b0;
        param_own_io <= 1'b0;
        program_copy <= 1'b0;
        data_copy <= 1'b0;
        align_request <= 1'b0;
        selftest_run <= 1'b0;
        cpu_hardware_fault_handler <= 1'b0;
        breakpoint_reject <= 1'b0;
        align_refused <= 1'b0;
        mem_clear <= 1'b0;
        diag_msg <= 1'b0;
        lockstep <= 1'b0;
    end
    else
    begin
        state_code <= enc_state(next_state); // RULE23
        // Handlers only on a master startup entry
        restart_handler <= (state == S_STOP) && (next_state == S_STARTUP) &&
            next_master && (start_type == `RCS_START_WARM); // RULE2 RULE12
        cold_restart_handler <= (state == S_STOP) && (next_state == S_STARTUP) &&
            next_master && (start_type == `RCS_START_COLD); // RULE2 RULE12
        param_switched_io <= (next_state == S_STARTUP) && next_master; // RULE11
        param_own_io <= (next_state == S_STARTUP); // RULE11 RULE12
        // Master serves partner alignment only from solo run
        program_copy <= is_master && (state == S_RUN) && !redundant &&
            areq_sync[0] && program_differs && !align_blocked; // RULE5 RULE14
        data_copy <= is_master && (state == S_RUN) && !redundant &&
            areq_sync[0] && !program_differs && !align_blocked; // RULE6 RULE14
        align_request <= (next_state == S_ALIGN) || (next_state == S_UPDATE);
        align_refused <= is_master && areq_sync[0] &&
            (align_blocked || state == S_HALT); // RULE4 RULE17
        selftest_run <= (next_state == S_ISOLATE); // RULE22
        cpu_hardware_fault_handler <= sbe_limit; // RULE21
        breakpoint_reject <= breakpoint_req && redundant; // RULE15
        // Clear acts on local memory only, and only while stopped
        mem_clear <= mem_clear_req && (state == S_STOP); // RULE10
        // Reserve held in stop while partner halts
        diag_msg <= (state == S_STOP) && start_req && !is_master &&
            s_partner_master && !s_partner_run; // RULE17
        lockstep <= next_redundant && (next_state == S_RUN) &&
            !next_swap_pending; // RULE7
    end
end

endmodule

// ==== verif/rcs_ctrl_asserts.sv ====
// Checker: timing relations between requests and state of rcs_ctrl.
// Assumes one ref_clk domain and a synchronous active-high reset.
`timescale 1ns/1ps
module rcs_ctrl_chk #(
    parameter [63:0] SBE_WINDOW_CYC = 64'h1
)
(
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Inputs watched
    input wire config_loaded,
    input wire breakpoint_req,
    input wire mem_clear_req,
    input wire [7:0] hw_version,
    input wire [7:0] fw_version,
    input wire [7:0] partner_hw_version,
    input wire [7:0] partner_fw_version,
    // Outputs watched
    input wire [3:0] state_code,
    input wire is_master,
    input wire restart_handler,
    input wire cold_restart_handler,
    input wire param_switched_io,
    input wire program_copy,
    input wire data_copy,
    input wire align_refused,
    input wire selftest_run,
    input wire breakpoint_reject,
    input wire mem_clear,
    input wire lockstep
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Stop is only left with a configuration present
    property p_stay_stop;
        state_code == 4'h0 && !config_loaded |=> state_code == 4'h0;
    endproperty
    a_stay_stop: assert property (p_stay_stop) else $error("left stop unconfigured");

    // Clear is answered one cycle on, in stop
    property p_clear;
        mem_clear_req && state_code == 4'h0 |=> mem_clear;
    endproperty
    a_clear: assert property (p_clear) else $error("clear not done");

    // Handlers only on the master, in startup
    property p_handler;
        restart_handler || cold_restart_handler |-> is_master && state_code == 4'h1;
    endproperty
    a_handler: assert property (p_handler) else $error("handler on standby");

    // Switched I/O set up by the master only
    property p_swio;
        param_switched_io |-> is_master && state_code == 4'h1;
    endproperty
    a_swio: assert property (p_swio) else $error("switched io by standby");

    // A refused alignment copies nothing
    property p_refuse;
        align_refused |-> !program_copy && !data_copy;
    endproperty
    a_refuse: assert property (p_refuse) else $error("copy while refused");

    // Breakpoints bounce while in lockstep
    property p_bp;
        breakpoint_req && lockstep |=> breakpoint_reject;
    endproperty
    a_bp: assert property (p_bp) else $error("breakpoint accepted");

    // Lockstep needs run and matching versions
    property p_versions;
        $rose(lockstep) |-> state_code == 4'h2 && hw_version == partner_hw_version
            && fw_version == partner_fw_version;
    endproperty
    a_versions: assert property (p_versions) else $error("lockstep bad versions");

    // Isolation follows lockstep and starts the self-test as standby
    property p_isolate;
        $rose(state_code == 4'h6) |-> $past(lockstep) && selftest_run && !is_master;
    endproperty
    a_isolate: assert property (p_isolate) else $error("bad isolation entry");

    // Halt only from startup or solo run
    property p_halt;
        $rose(state_code == 4'h5) |-> !$past(lockstep)
            && ($past(state_code) == 4'h1 || $past(state_code) == 4'h2);
    endproperty
    a_halt: assert property (p_halt) else $error("bad halt entry");
endmodule

bind rcs_ctrl rcs_ctrl_chk #(.SBE_WINDOW_CYC(SBE_WINDOW_CYC)) u_chk (.*);

// ==== verif/rcs_partner.sv ====
// Partner CPU model on the far side of the synchronisation link.
// Assumes the testbench sets its role through four level inputs.
`timescale 1ns/1ps
module rcs_partner #(
    parameter [7:0] HW = 8'h11,
    parameter [7:0] FW = 8'h22
)
(
    // Clock
    input wire ref_clk,
    // Role from the testbench
    input wire up,
    input wire master,
    input wire ask_align,
    input wire held,
    // Link pins
    output reg link_ok,
    output reg partner_alive,
    output reg partner_is_master,
    output reg partner_run,
    output reg partner_align_req,
    output wire [7:0] partner_hw_version,
    output wire [7:0] partner_fw_version
);
    // Dead partner shows inverted versions so stale values never match
    assign partner_hw_version = up ? HW : ~HW;
    assign partner_fw_version = up ? FW : ~FW;

    // A live master stays in run while this CPU aligns or updates
    always @(posedge ref_clk)
    begin
        link_ok <= up;
        partner_alive <= up;
        partner_run <= up && !held;
        partner_is_master <= up && master;
        partner_align_req <= up && ask_align && !master;
    end
endmodule

// ==== verif/testbench.sv ====
// Testbench for the redundant CPU state controller with a partner model.
// Assumes design, partner and checker compiled first, defs header on the path.
`timescale 1ns/1ps
`include "rcs_defs.vh"
module testbench;
    localparam int START = 0, HALT = 2, BRK = 4, CLR = 5, SDONE = 6, ADONE = 7;
    localparam int UDONE = 8, TDONE = 9, CSUM = 11, MBIT = 12, SBIT = 13, MISM = 14;
    int failures = 0;
    int checked = 0;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    // Pulse requests share one vector so one task drives them all
    logic [14:0] p = 15'h0;
    wire start_req = p[0], stop_req = p[1], halt_req = p[2], resume_req = p[3];
    wire breakpoint_req = p[4], mem_clear_req = p[5], startup_done = p[6], align_done = p[7];
    wire update_done = p[8], selftest_done = p[9], prog_error_trap = p[10];
    wire checksum_error = p[11], multibit_error = p[12], single_bit_error = p[13];
    wire memory_image_mismatch = p[14];
    // Levels
    logic start_type = 1'h0, config_loaded = 1'h0, mismatch_to_stop = 1'h0;
    logic monitor_open = 1'h0, watch_active = 1'h0, program_differs = 1'h0;
    logic selftest_fault = 1'h0, p_up = 1'h0, p_master = 1'h0, p_ask = 1'h0, p_hold = 1'h0;
    logic [7:0] hw_version = 8'h11, fw_version = 8'h22;
    // Link pins and design outputs
    wire link_ok, partner_alive, partner_is_master, partner_run, partner_align_req;
    wire [7:0] partner_hw_version, partner_fw_version;
    wire [3:0] state_code;
    wire is_master, restart_handler, cold_restart_handler, param_switched_io, param_own_io;
    wire program_copy, data_copy, align_request, selftest_run, cpu_hardware_fault_handler;
    wire breakpoint_reject, align_refused, mem_clear, diag_msg, lockstep;

    // Short error window keeps the single-bit count reachable
    rcs_ctrl #(.SBE_WINDOW_CYC(64'h3E8)) dut (.*);
    rcs_partner peer (.up(p_up), .master(p_master), .ask_align(p_ask), .held(p_hold), .*);

    // Clock
    always #5 ref_clk = ~ref_clk;

    // Inputs move 1 ns after the edge so outputs have settled
    task tick;
        @(posedge ref_clk);
        #1;
    endtask

    task pulse(input int i);
        p[i] <= 1'h1;
        tick;
        p[i] <= 1'h0;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task finish_test;
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Three cycles of reset, then time for the pin synchronisers
    task do_reset;
        rst <= 1'h1;
        repeat (3) tick;
        rst <= 1'h0;
        repeat (3) tick;
    endtask

    // Bounded wait for a state
    task wait_state(input logic [3:0] s);
        for (int i = 0; i < 20 && state_code !== s; i++)
            tick;
        chk(state_code, s);
    endtask

    task t_stop;
        do_reset;
        chk({state_code, is_master}, 5'h00);
        pulse(START);
        tick;
        chk(state_code, `RCS_ST_STOP);
        pulse(CLR);
        chk(mem_clear, 1'h1);
        // Halted master: reserve refuses to start and reports it
        config_loaded <= 1'h1;
        p_up <= 1'h1;
        p_master <= 1'h1;
        p_hold <= 1'h1;
        repeat (4) tick;
        pulse(START);
        chk({state_code, diag_msg}, 5'h01);
        p_up <= 1'h0;
        p_master <= 1'h0;
        p_hold <= 1'h0;
    endtask

    task t_master;
        config_loaded <= 1'h1;
        for (int k = 0; k < 2; k++)
        begin
            start_type <= k[0];
            do_reset;
            pulse(START);
            chk(state_code, `RCS_ST_STARTUP);
            chk({is_master, cold_restart_handler, restart_handler}, {1'h1, k[0], ~k[0]});
            chk({param_switched_io, param_own_io}, 2'h3);
        end
        pulse(SDONE);
        chk(state_code, `RCS_ST_RUN);
        monitor_open <= 1'h1;
        p_up <= 1'h1;
        p_ask <= 1'h1;
        repeat (6) tick;
        chk({align_refused, program_copy, data_copy}, 3'h4);
        monitor_open <= 1'h0;
        program_differs <= 1'h1;
        tick;
        chk({align_refused, program_copy, data_copy}, 3'h2);
        program_differs <= 1'h0;
        tick;
        chk({align_refused, program_copy, data_copy}, 3'h1);
        pulse(HALT);
        chk(state_code, `RCS_ST_HALT);
        tick;
        chk(align_refused, 1'h1);
        p_ask <= 1'h0;
    endtask

    // Standby start into lockstep behind a running master
    task to_redundant;
        config_loaded <= 1'h1;
        p_up <= 1'h1;
        p_master <= 1'h1;
        do_reset;
        pulse(START);
        chk({is_master, restart_handler, cold_restart_handler, param_switched_io}, 4'h0);
        chk(param_own_io, 1'h1);
        pulse(SDONE);
        program_differs <= 1'h1;
        wait_state(`RCS_ST_ALIGN);
        chk(align_request, 1'h1);
        pulse(ADONE);
        wait_state(`RCS_ST_UPDATE);
        pulse(UDONE);
        wait_state(`RCS_ST_RUN);
        repeat (2) tick;
        chk(lockstep, 1'h1);
    endtask

    task t_faults;
        to_redundant;
        pulse(BRK);
        chk(breakpoint_reject, 1'h1);
        pulse(HALT);
        tick;
        chk(state_code, `RCS_ST_RUN);
        pulse(SBIT);
        tick;
        pulse(SBIT);
        // Handler pulse trails the limit flag by one register stage
        tick;
        chk(cpu_hardware_fault_handler, 1'h1);
        chk(state_code, `RCS_ST_RUN);
        pulse(CSUM);
        chk({state_code, selftest_run, is_master}, 6'h1A);
        selftest_fault <= 1'h1;
        pulse(TDONE);
        wait_state(`RCS_ST_FAILED);
        selftest_fault <= 1'h0;
        to_redundant;
        pulse(MBIT);
        wait_state(`RCS_ST_ISOLATE);
        pulse(TDONE);
        wait_state(`RCS_ST_ALIGN);
        to_redundant;
        pulse(MISM);
        chk(state_code, `RCS_ST_ISOLATE);
        to_redundant;
        mismatch_to_stop <= 1'h1;
        pulse(MISM);
        wait_state(`RCS_ST_STOP);
        mismatch_to_stop <= 1'h0;
        to_redundant;
        p_up <= 1'h0;
        repeat (6) tick;
        chk(lockstep, 1'h0);
    endtask

    // Main sequence
    initial
    begin
        t_stop;
        t_master;
        t_faults;
        finish_test;
    end

    // Watchdog, well beyond the roughly 120 cycles the tests need
    initial
    begin
        #100000;
        failures++;
        finish_test;
    end
endmodule
